// >>> logic/fcid_decoder_top.sv
// digital back end of the caller-id fsk decoder: serial, packets, events
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// [RULE_01] four event sources: raw falling edge, ring, carrier, packet byte
// [RULE_02] raw edge enabled by a one; other three enabled by mask zero
// [RULE_03] every event sets its flag even when its interrupt is off
// [RULE_04] enabled event with peripheral enable sets request, vector 10H
// [RULE_05] software, not hardware, clears the four event flags
// [RULE_06] a flag still set suppresses further interrupts from its source
// [RULE_07] power-down stops decoding; flags and data stay accessible
// [RULE_08] raw edge enable blocks ring, carrier and packet interrupts
// [RULE_09] ring flag on falling ring detect; interrupts if unmasked, enabled
// [RULE_10] decoder runs only while power-down is zero
// [RULE_11] carrier detection sets carrier flag; interrupts if unmasked
// [RULE_12] raw bit follows the whole demodulated stream
// [RULE_13] cooked bit is the raw stream without the seizure pattern
// [RULE_14] without fsk data both serial bits are held high
// [RULE_15] ten bits per character, first and tenth dropped, eight kept
// [RULE_16] valid byte goes to packet data and sets packet flag
// [RULE_17] source select picks raw or cooked stream for the packer
// [RULE_18] a character starts only on a zero start bit
// [RULE_19] with cooked selected the seizure pattern is never packed
// [RULE_20] software keeps the part at full speed while decoding
// [RULE_21] ring detection and its flag work even in power-down
// [RULE_22] packet data holds until next byte; writing zero clears a flag
module fcid_decoder_top #(
  parameter int MARK_RUN = fcid_pkg::FCID_MARK_RUN,
  parameter int DATA_BITS = fcid_pkg::FCID_DATA_BITS
) (
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_DEMOD_BIT,
  input wire logic I_BIT_STROBE,
  input wire logic I_DATA_DETECT,
  input wire logic I_CARRIER_DETECT,
  input wire logic I_RING_DETECT_INTERNAL,
  input wire logic I_DECODER_POWER_DOWN,
  input wire logic I_PACKET_SOURCE_SELECT,
  input wire logic I_RAW_EDGE_IRQ_ENABLE,
  input wire logic I_RING_IRQ_MASK,
  input wire logic I_CARRIER_IRQ_MASK,
  input wire logic I_PACKET_IRQ_MASK,
  input wire logic I_PERIPHERAL_IRQ_ENABLE,
  input wire logic I_CLR_RAW_EDGE_FLAG,
  input wire logic I_CLR_RING_EVENT_FLAG,
  input wire logic I_CLR_CARRIER_EVENT_FLAG,
  input wire logic I_CLR_PACKET_READY_FLAG,
  input wire logic I_PERIPHERAL_ACK,
  output logic O_RAW_SERIAL_BIT,
  output logic O_COOKED_SERIAL_BIT,
  output logic O_CARRIER_STATUS,
  output logic [DATA_BITS-1:0] O_PACKET_DATA,
  output logic O_RAW_EDGE_FLAG,
  output logic O_RING_EVENT_FLAG,
  output logic O_CARRIER_EVENT_FLAG,
  output logic O_PACKET_READY_FLAG,
  output logic O_PERIPHERAL_REQUEST_FLAG,
  output logic [7:0] O_VECTOR_ADDR
);
  localparam int NS = fcid_pkg::FCID_NUM_SRC;

  logic active;
  logic powered;
  logic mark_seen;
  logic cooked_src;
  logic pack_bit;
  logic [DATA_BITS-1:0] pack_byte;
  logic pack_valid;
  logic raw_prev;
  logic carrier_prev;
  logic ring_prev;
  logic [NS-1:0] ev;
  logic [NS-1:0] clr;
  logic [NS-1:0] en;
  logic [NS-1:0] flag;
  logic [NS-1:0] req;
  logic any_req;

  // request from one source: an enabled event that finds its flag clear
  function automatic logic fcid_req_gate(input logic event_hit,
                                         input logic flag_now,
                                         input logic enable);
    fcid_req_gate = event_hit && !flag_now && enable;
  endfunction : fcid_req_gate

  // decoding runs only out of power-down and while fsk data is seen
  assign powered = !I_DECODER_POWER_DOWN; // RULE_10
  assign active = powered && I_DATA_DETECT; // RULE_07

  // end-of-seizure detector feeding the cooked stream
  fcid_seizure_strip #(
    .MARK_RUN(MARK_RUN)
  ) u_strip (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_active(active),
    .i_strobe(I_BIT_STROBE),
    .i_bit(I_DEMOD_BIT),
    .o_mark_seen(mark_seen)
  );

  // cooked stream stays high through the alternating pattern
  assign cooked_src = mark_seen ? I_DEMOD_BIT :
                      fcid_pkg::FCID_SERIAL_IDLE; // RULE_19
  // packer input choice; cooked keeps sync bits out of the bytes
  assign pack_bit = I_PACKET_SOURCE_SELECT ? cooked_src : I_DEMOD_BIT; // RULE_17

  fcid_packer #(
    .DATA_BITS(DATA_BITS)
  ) u_packer (
    .i_clk(I_CLK),
    .i_rst_b(I_RST_B),
    .i_enable(active),
    .i_strobe(I_BIT_STROBE),
    .i_bit(pack_bit),
    .o_byte(pack_byte),
    .o_valid(pack_valid)
  );

  // raw serial bit: full stream while data is present out of power-down, else idle high
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_RAW_SERIAL_BIT <= fcid_pkg::FCID_SERIAL_IDLE;
    end else if (active) begin
      O_RAW_SERIAL_BIT <= I_DEMOD_BIT; // RULE_12
    end else begin
      O_RAW_SERIAL_BIT <= fcid_pkg::FCID_SERIAL_IDLE; // RULE_14
    end
  end

  // cooked serial bit: same timing as raw so the two line up
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_COOKED_SERIAL_BIT <= fcid_pkg::FCID_SERIAL_IDLE;
    end else if (active) begin
      O_COOKED_SERIAL_BIT <= cooked_src; // RULE_13
    end else begin
      O_COOKED_SERIAL_BIT <= fcid_pkg::FCID_SERIAL_IDLE; // RULE_14
    end
  end

  // history for the edge detectors; ring history runs even in power-down
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      raw_prev <= fcid_pkg::FCID_SERIAL_IDLE;
      carrier_prev <= 1'b0;
      ring_prev <= 1'b1;
      O_CARRIER_STATUS <= 1'b0;
    end else begin
      raw_prev <= O_RAW_SERIAL_BIT;
      carrier_prev <= powered && I_CARRIER_DETECT;
      ring_prev <= I_RING_DETECT_INTERNAL; // RULE_21
      O_CARRIER_STATUS <= powered && I_CARRIER_DETECT;
    end
  end

  // the four event sources
  assign ev[fcid_pkg::FCID_SRC_RAW] = powered && raw_prev &&
                                      !O_RAW_SERIAL_BIT; // RULE_01
  assign ev[fcid_pkg::FCID_SRC_RING] = ring_prev &&
                                       !I_RING_DETECT_INTERNAL; // RULE_09
  assign ev[fcid_pkg::FCID_SRC_CARRIER] = powered && I_CARRIER_DETECT &&
                                          !carrier_prev; // RULE_11
  assign ev[fcid_pkg::FCID_SRC_PACKET] = powered && pack_valid; // RULE_16

  // software clears, one write of zero per flag
  assign clr[fcid_pkg::FCID_SRC_RAW] = I_CLR_RAW_EDGE_FLAG;
  assign clr[fcid_pkg::FCID_SRC_RING] = I_CLR_RING_EVENT_FLAG;
  assign clr[fcid_pkg::FCID_SRC_CARRIER] = I_CLR_CARRIER_EVENT_FLAG;
  assign clr[fcid_pkg::FCID_SRC_PACKET] = I_CLR_PACKET_READY_FLAG;

  // raw edge enable is active high and shuts out the masked three
  assign en[fcid_pkg::FCID_SRC_RAW] = I_RAW_EDGE_IRQ_ENABLE; // RULE_02
  assign en[fcid_pkg::FCID_SRC_RING] = !I_RING_IRQ_MASK &&
                                       !I_RAW_EDGE_IRQ_ENABLE; // RULE_08
  assign en[fcid_pkg::FCID_SRC_CARRIER] = !I_CARRIER_IRQ_MASK &&
                                          !I_RAW_EDGE_IRQ_ENABLE; // RULE_08
  assign en[fcid_pkg::FCID_SRC_PACKET] = !I_PACKET_IRQ_MASK &&
                                         !I_RAW_EDGE_IRQ_ENABLE; // RULE_02

  // one clock domain: every assertion below, loop ones included, uses it
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);

  // sticky flags; a set in the clearing cycle wins over the clear
  generate
    for (genvar i = 0; i < NS; i++) begin : g_src
      always_ff @(posedge I_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
          flag[i] <= fcid_pkg::FCID_FLAG_RESET;
        end else if (ev[i]) begin
          flag[i] <= 1'b1; // RULE_03
        end else if (clr[i]) begin
          flag[i] <= 1'b0; // RULE_22
        end
      end

      // a flag left set holds back repeat requests
      assign req[i] = fcid_req_gate(ev[i], flag[i], en[i]); // RULE_06

      a_flag_sets: assert property ( // RULE_03
        ev[i] |=> flag[i])
        else $error("event did not set its flag");

      a_flag_blocks: assert property ( // RULE_06
        flag[i] |-> !req[i])
        else $error("request raised while flag still set");

      a_flag_clears: assert property ( // RULE_22
        (clr[i] && !ev[i]) |=> !flag[i])
        else $error("flag not cleared by software write");
    end
  endgenerate

  assign O_RAW_EDGE_FLAG = flag[fcid_pkg::FCID_SRC_RAW];
  assign O_RING_EVENT_FLAG = flag[fcid_pkg::FCID_SRC_RING];
  assign O_CARRIER_EVENT_FLAG = flag[fcid_pkg::FCID_SRC_CARRIER];
  assign O_PACKET_READY_FLAG = flag[fcid_pkg::FCID_SRC_PACKET];
  assign any_req = |req;

  // peripheral request and vector; acknowledge loses to a new request
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PERIPHERAL_REQUEST_FLAG <= 1'b0;
      O_VECTOR_ADDR <= fcid_pkg::FCID_VECTOR_RESET;
    end else if (any_req && I_PERIPHERAL_IRQ_ENABLE) begin
      O_PERIPHERAL_REQUEST_FLAG <= 1'b1; // RULE_04
      O_VECTOR_ADDR <= fcid_pkg::FCID_VECTOR_ADDR; // RULE_04
    end else if (I_PERIPHERAL_ACK) begin
      O_PERIPHERAL_REQUEST_FLAG <= 1'b0;
    end
  end

  // packet data keeps its last byte; load only on a valid byte
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      O_PACKET_DATA <= fcid_pkg::FCID_PACKET_RESET;
    end else if (ev[fcid_pkg::FCID_SRC_PACKET]) begin
      O_PACKET_DATA <= pack_byte; // RULE_16
    end
  end

  // a byte leaving the packer lands in data and flag together
  sequence s_byte_done;
    powered && pack_valid;
  endsequence

  sequence s_byte_stored;
    (O_PACKET_DATA == $past(pack_byte)) && O_PACKET_READY_FLAG;
  endsequence

  a_idle_high: assert property ( // RULE_14
    !active |=> (O_RAW_SERIAL_BIT && O_COOKED_SERIAL_BIT))
    else $error("serial bits not idle high without data");

  a_raw_follows: assert property ( // RULE_12
    active |=> (O_RAW_SERIAL_BIT == $past(I_DEMOD_BIT)))
    else $error("raw bit does not follow the stream");

  a_seizure_hidden: assert property ( // RULE_13
    (active && !mark_seen) |=> O_COOKED_SERIAL_BIT)
    else $error("seizure pattern leaked onto cooked bit");

  a_cooked_tracks: assert property ( // RULE_13
    (active && mark_seen) |=> (O_COOKED_SERIAL_BIT == O_RAW_SERIAL_BIT))
    else $error("cooked bit differs from raw after mark");

  a_byte_stored: assert property ( // RULE_16
    s_byte_done |=> s_byte_stored)
    else $error("packed byte not stored with its flag");

  a_data_holds: assert property ( // RULE_22
    !ev[fcid_pkg::FCID_SRC_PACKET] |=> $stable(O_PACKET_DATA))
    else $error("packet data changed without a byte");

  a_raw_blocks: assert property ( // RULE_08
    I_RAW_EDGE_IRQ_ENABLE |-> (req[3:1] == 3'b000))
    else $error("masked source passed while raw edge enabled");

  a_periph_set: assert property ( // RULE_04
    (any_req && I_PERIPHERAL_IRQ_ENABLE) |=>
      (O_PERIPHERAL_REQUEST_FLAG && O_VECTOR_ADDR == 8'h10))
    else $error("peripheral request or vector missing");

  a_periph_off: assert property ( // RULE_04
    (!I_PERIPHERAL_IRQ_ENABLE && !O_PERIPHERAL_REQUEST_FLAG)
      |=> !O_PERIPHERAL_REQUEST_FLAG)
    else $error("peripheral request while disabled");

  a_pd_quiet: assert property ( // RULE_07
    I_DECODER_POWER_DOWN |-> (ev[0] == 1'b0 && ev[2] == 1'b0 &&
                              ev[3] == 1'b0))
    else $error("decoder event during power-down");

  a_ring_alive: assert property ( // RULE_21
    ($fell(I_RING_DETECT_INTERNAL) && I_DECODER_POWER_DOWN)
      |-> ##0 1'b1 ##1 O_RING_EVENT_FLAG)
    else $error("ring flag lost in power-down");

  a_cooked_no_sync: assert property ( // RULE_19
    (I_PACKET_SOURCE_SELECT && active && !mark_seen) |-> pack_bit)
    else $error("sync bit routed to packer on cooked select");

  a_ack_clears: assert property ( // RULE_04
    (I_PERIPHERAL_ACK && !(any_req && I_PERIPHERAL_IRQ_ENABLE))
      |=> !O_PERIPHERAL_REQUEST_FLAG)
    else $error("peripheral request not cleared by acknowledge");

  a_raw_to_packer: assert property ( // RULE_17
    !I_PACKET_SOURCE_SELECT |-> (pack_bit == I_DEMOD_BIT))
    else $error("raw stream not routed to packer");

  a_carrier_flag: assert property ( // RULE_11
    (powered && I_CARRIER_DETECT && !carrier_prev)
      |=> O_CARRIER_EVENT_FLAG)
    else $error("carrier detection did not set its flag");
endmodule : fcid_decoder_top
`default_nettype wire

// >>> logic/fcid_packer.sv
// packer of ten-bit serial characters into bytes
`timescale 1ns/10ps
`default_nettype none
module fcid_packer #(
  parameter int DATA_BITS = fcid_pkg::FCID_DATA_BITS
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_enable,
  input wire logic i_strobe,
  input wire logic i_bit,
  output logic [DATA_BITS-1:0] o_byte,
  output logic o_valid
);
  localparam int CW = $clog2(DATA_BITS + 1);
  fcid_pkg::fcid_pack_state_type state;
  logic [CW-1:0] cnt;

  generate
    if (DATA_BITS + 2 != fcid_pkg::FCID_CHAR_BITS) begin : g_bad_width
      $error("DATA_BITS must leave room for start and stop bits");
    end
  endgenerate

  // only a zero start bit opens a character, so steady mark is skipped
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= fcid_pkg::FCID_PK_IDLE;
      cnt <= '0;
      o_byte <= '0;
    end else if (!i_enable) begin
      state <= fcid_pkg::FCID_PK_IDLE;
      cnt <= '0;
    end else if (i_strobe) begin
      case (state)
        fcid_pkg::FCID_PK_IDLE: begin
          cnt <= '0;
          if (!i_bit) begin
            state <= fcid_pkg::FCID_PK_SHIFT; // RULE_18
          end
        end
        fcid_pkg::FCID_PK_SHIFT: begin
          o_byte <= {i_bit, o_byte[DATA_BITS-1:1]}; // RULE_15
          cnt <= cnt + 1'b1;
          if (cnt == CW'(DATA_BITS - 1)) begin
            state <= fcid_pkg::FCID_PK_STOP;
          end
        end
        default: begin
          state <= fcid_pkg::FCID_PK_IDLE; // tenth bit dropped
        end
      endcase
    end
  end

  // byte is complete once the tenth bit has gone by
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_valid <= 1'b0;
    end else begin
      o_valid <= i_enable && i_strobe &&
                 (state == fcid_pkg::FCID_PK_STOP); // RULE_15
    end
  end

  a_idle_on_mark: assert property (@(posedge i_clk) disable iff (!i_rst_b) // RULE_18
    (i_enable && i_strobe && i_bit && state == fcid_pkg::FCID_PK_IDLE)
    |=> state == fcid_pkg::FCID_PK_IDLE)
    else $error("mark bit opened a character");
endmodule : fcid_packer
`default_nettype wire

// >>> logic/fcid_pkg.sv
// shared constants and types of the caller-id fsk decoder back end
`default_nettype none
package fcid_pkg;
  // entry of the shared peripheral vector, loaded on a peripheral request
  localparam logic [7:0] FCID_VECTOR_ADDR = 8'h10;
  localparam logic [7:0] FCID_VECTOR_RESET = 8'h00;
  // packet data register after reset
  localparam logic [7:0] FCID_PACKET_RESET = 8'h00;
  // serial lines idle high, flags idle low
  localparam logic FCID_SERIAL_IDLE = 1'b1;
  localparam logic FCID_FLAG_RESET = 1'b0;
  // character framing: one start bit, data bits, one dropped stop bit
  localparam int FCID_CHAR_BITS = 10;
  localparam int FCID_DATA_BITS = 8;
  // consecutive marks that end the alternating seizure pattern
  localparam int FCID_MARK_RUN = 4;
  // event source positions in the flag vectors
  localparam int FCID_SRC_RAW = 0;
  localparam int FCID_SRC_RING = 1;
  localparam int FCID_SRC_CARRIER = 2;
  localparam int FCID_SRC_PACKET = 3;
  localparam int FCID_NUM_SRC = 4;
  // packer states, gray along idle -> shift -> stop
  typedef enum logic [1:0] {
    FCID_PK_IDLE = 2'b00,
    FCID_PK_SHIFT = 2'b01,
    FCID_PK_STOP = 2'b11
  } fcid_pack_state_type;
endpackage : fcid_pkg
`default_nettype wire

// >>> logic/fcid_seizure_strip.sv
// detector for the end of the alternating channel-seizure pattern
`timescale 1ns/10ps
`default_nettype none
module fcid_seizure_strip #(
  parameter int MARK_RUN = fcid_pkg::FCID_MARK_RUN
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_active,
  input wire logic i_strobe,
  input wire logic i_bit,
  output logic o_mark_seen
);
  localparam int CW = $clog2(MARK_RUN + 1);
  logic [CW-1:0] run;

  // alternation never holds two marks in a row, so a run proves the mark
  generate
    if (MARK_RUN < 2) begin : g_bad_run
      $error("MARK_RUN must be at least 2");
    end
  endgenerate

  // count consecutive mark bits on each bit strobe
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run <= '0;
    end else if (!i_active) begin
      run <= '0;
    end else if (i_strobe) begin
      run <= i_bit ? ((run == CW'(MARK_RUN)) ? run : run + 1'b1) : '0;
    end
  end

  // sticky until the frame ends; the data keeps its own marks
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_mark_seen <= 1'b0;
    end else if (!i_active) begin
      o_mark_seen <= 1'b0;
    end else if (i_strobe && i_bit && (run == CW'(MARK_RUN - 1))) begin
      o_mark_seen <= 1'b1;
    end
  end
endmodule : fcid_seizure_strip
`default_nettype wire

// >>> tb/fcid_line_model.sv
// model of the analog fsk front end that feeds the decoder back end
`timescale 1ns/10ps
`default_nettype none
module fcid_line_model (
  input wire logic i_clk,
  output logic o_demod_bit,
  output logic o_strobe,
  output logic o_data_detect,
  output logic o_carrier
);
  // low while a frame owns the bit, so junk never races a frame drive
  logic junk_on;
  initial begin
    junk_on = 1'b1;
    o_demod_bit = 1'b1;
    o_strobe = 1'b0;
    o_data_detect = 1'b0;
    o_carrier = 1'b0;
  end
  // no data detected: the demodulator output is junk, so it keeps changing
  always @(posedge i_clk) begin
    if (junk_on) begin
      o_demod_bit <= ~o_demod_bit;
    end
  end
  // strobes come from the system clock, so the part stays at full speed
  task automatic frame_on();
    junk_on = 1'b0;
    @(posedge i_clk);
    o_carrier <= 1'b1;
    o_data_detect <= 1'b1;
    o_demod_bit <= 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : frame_on
  task automatic frame_off();
    @(posedge i_clk);
    o_carrier <= 1'b0;
    o_data_detect <= 1'b0;
    junk_on = 1'b1;
    repeat (2) @(posedge i_clk);
  endtask : frame_off
  // one bit every four cycles, strobe pulse at the bit's first cycle
  task automatic bit_out(input logic b);
    @(posedge i_clk);
    o_demod_bit <= b;
    o_strobe <= 1'b1;
    @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (2) @(posedge i_clk);
  endtask : bit_out
  // alternating seizure pattern, starting with a space
  task automatic seize(input int n);
    for (int i = 0; i < n; i++) begin
      bit_out(i[0]);
    end
  endtask : seize
  // start bit, eight data bits lsb first, stop bit
  task automatic char_out(input logic [7:0] d);
    bit_out(1'b0);
    for (int i = 0; i < 8; i++) begin
      bit_out(d[i]);
    end
    bit_out(1'b1);
  endtask : char_out
endmodule : fcid_line_model
`default_nettype wire

// >>> tb/test_fcid_decoder_top.sv
// self-checking bench of the caller-id fsk decoder back end
`timescale 1ns/10ps
`default_nettype none
module test_fcid_decoder_top;
  logic clk, rst_b, ring, pd, sel, raw_en, ring_irq_mask, carrier_irq_mask, pmsk, pen, ack;
  logic clr_raw, clr_ring, clr_car, clr_pkt, exp_raw, seize_chk, mark_chk;
  wire logic demod, strobe, detect, carrier;
  wire logic raw, cooked, car_st, f_raw, f_ring, f_car, f_pkt, req;
  wire logic [7:0] data, vec;
  int bad_count = 0;
  int checked = 0;
  fcid_line_model line_u (.i_clk(clk), .o_demod_bit(demod),
    .o_strobe(strobe), .o_data_detect(detect), .o_carrier(carrier));
  fcid_decoder_top #(.MARK_RUN(4), .DATA_BITS(8)) dut_u (
    .I_CLK(clk), .I_RST_B(rst_b), .I_DEMOD_BIT(demod),
    .I_BIT_STROBE(strobe), .I_DATA_DETECT(detect),
    .I_CARRIER_DETECT(carrier), .I_RING_DETECT_INTERNAL(ring),
    .I_DECODER_POWER_DOWN(pd), .I_PACKET_SOURCE_SELECT(sel),
    .I_RAW_EDGE_IRQ_ENABLE(raw_en), .I_RING_IRQ_MASK(ring_irq_mask),
    .I_CARRIER_IRQ_MASK(carrier_irq_mask), .I_PACKET_IRQ_MASK(pmsk),
    .I_PERIPHERAL_IRQ_ENABLE(pen), .I_CLR_RAW_EDGE_FLAG(clr_raw),
    .I_CLR_RING_EVENT_FLAG(clr_ring), .I_CLR_CARRIER_EVENT_FLAG(clr_car),
    .I_CLR_PACKET_READY_FLAG(clr_pkt), .I_PERIPHERAL_ACK(ack),
    .O_RAW_SERIAL_BIT(raw), .O_COOKED_SERIAL_BIT(cooked),
    .O_CARRIER_STATUS(car_st), .O_PACKET_DATA(data),
    .O_RAW_EDGE_FLAG(f_raw), .O_RING_EVENT_FLAG(f_ring),
    .O_CARRIER_EVENT_FLAG(f_car), .O_PACKET_READY_FLAG(f_pkt),
    .O_PERIPHERAL_REQUEST_FLAG(req), .O_VECTOR_ADDR(vec));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // let two edges land before looking at outputs
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  // software writes zero to every event flag
  task automatic clr_all();
    @(posedge clk);
    {clr_raw, clr_ring, clr_car, clr_pkt} <= 4'h f;
    @(posedge clk);
    {clr_raw, clr_ring, clr_car, clr_pkt} <= 4'h 0;
  endtask : clr_all
  task automatic ack_req();
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
  endtask : ack_req
  task automatic ring_pulse();
    @(posedge clk);
    ring <= 1'b0;
    repeat (3) @(posedge clk);
    ring <= 1'b1;
    settle();
  endtask : ring_pulse
  // expected raw bit: the input one cycle late while active, else high
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      exp_raw <= 1'b1;
    end else begin
      exp_raw <= (!pd && detect) ? demod : 1'b1;
    end
  end
  // raw bit compared every cycle at the falling edge, cooked bit only while seize_chk or mark_chk is set
  always @(negedge clk) begin
    if (rst_b) begin
      check(raw, exp_raw);
      if (seize_chk) begin
        check(cooked, 1'b1);
      end
      if (mark_chk) begin
        check(cooked, exp_raw);
      end
    end
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    ring = 1'b1;
    pd = 1'b0;
    sel = 1'b1;
    raw_en = 1'b0;
    ring_irq_mask = 1'b1;
    carrier_irq_mask = 1'b1;
    pmsk = 1'b1;
    pen = 1'b1;
    ack = 1'b0;
    {clr_raw, clr_ring, clr_car, clr_pkt} = 4'h 0;
    {seize_chk, mark_chk} = 2'b00;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    check({cooked, f_raw, f_ring, f_car, f_pkt, req}, 6'h 20);
    check(data, fcid_pkg::FCID_PACKET_RESET);
    check(vec, fcid_pkg::FCID_VECTOR_RESET);
    // cooked stream, everything masked: flags set, no request
    line_u.frame_on();
    settle();
    check(car_st, 1'b1);
    seize_chk = 1'b1;
    line_u.seize(20);
    seize_chk = 1'b0;
    settle();
    check({f_pkt, data}, 9'h 000);
    repeat (6) line_u.bit_out(1'b1);
    mark_chk = 1'b1;
    line_u.char_out(8'h a5);
    settle();
    check({f_pkt, data}, 9'h 1a5);
    check(req, 1'b0);
    clr_all();
    settle();
    check(f_pkt, 1'b0);
    line_u.char_out(8'h 3c);
    settle();
    check({f_pkt, data}, 9'h 13c);
    mark_chk = 1'b0;
    line_u.frame_off();
    check({f_raw, f_car, f_pkt, req}, 4'h a);
    // raw stream: seizure is packed, carrier and packet interrupts
    clr_all();
    {sel, carrier_irq_mask, pmsk} <= 3'b000;
    line_u.frame_on();
    settle();
    check(req, 1'b1);
    ack_req();
    settle();
    check(req, 1'b0);
    line_u.seize(10);
    settle();
    check(data, 8'h 55);
    check(req, 1'b1);
    ack_req();
    line_u.seize(10);
    settle();
    check(req, 1'b0);
    repeat (6) line_u.bit_out(1'b1);
    line_u.char_out(8'h c3);
    settle();
    check(data, 8'h c3);
    line_u.frame_off();
    // ring masked, then unmasked, then suppressed by a set flag
    clr_all();
    {carrier_irq_mask, pmsk} <= 2'b11;
    ring_pulse();
    check({f_ring, req}, 2'b10);
    clr_all();
    ring_irq_mask <= 1'b0;
    ring_pulse();
    check({f_ring, req}, 2'b11);
    check(vec, fcid_pkg::FCID_VECTOR_ADDR);
    ack_req();
    ring_pulse();
    check(req, 1'b0);
    // peripheral interrupt off: flag still sets, no request
    clr_all();
    pen <= 1'b0;
    ring_pulse();
    check({f_ring, req}, 2'b10);
    pen <= 1'b1;
    // power-down: ring still works, decoding stops
    clr_all();
    pd <= 1'b1;
    ring_pulse();
    check({f_ring, req}, 2'b11);
    ack_req();
    line_u.frame_on();
    settle();
    check(car_st, 1'b0);
    line_u.char_out(8'h 96);
    settle();
    check({f_car, f_pkt, data}, 10'h 0c3);
    line_u.frame_off();
    pd <= 1'b0;
    // raw edge enable blocks the unmasked ring and raises its own request
    clr_all();
    raw_en <= 1'b1;
    ring_pulse();
    check({f_ring, req}, 2'b10);
    line_u.frame_on();
    line_u.bit_out(1'b0);
    settle();
    check({f_raw, req}, 2'b11);
    line_u.frame_off();
    test_done();
  end
endmodule : test_fcid_decoder_top
`default_nettype wire
